// ---- thc_pkg.sv ----
package thc_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned SIMULT_MS = 500;
   localparam int unsigned RESPONSE_MS = 15;
   localparam int unsigned RECOVERY_MS = 150;
   localparam int unsigned EARTH_OFF_S = 60;
   // Every time is an exact whole multiple of the clock period; none round up or down.
   localparam int unsigned SIMULT_CYC = SIMULT_MS * (CLK_HZ / 1000);
   localparam int unsigned RESPONSE_CYC = RESPONSE_MS * (CLK_HZ / 1000);
   localparam int unsigned RECOVERY_CYC = RECOVERY_MS * (CLK_HZ / 1000);
   localparam int unsigned EARTH_OFF_CYC = EARTH_OFF_S * CLK_HZ;
   localparam int unsigned FILT_LEN = 3;
   typedef enum logic [2:0] {
      THC_WAIT_RELEASE,
      THC_IDLE,
      THC_TIMING,
      THC_ACTIVE,
      THC_LOCKED
   } thc_state_e;
endpackage

// ---- thc_sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface thc_sync_if #(parameter int N = 8);
   logic [N-1:0] raw;
   logic [N-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface
`default_nettype wire

// ---- thc_input_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Three-stage synchroniser; a change is accepted when stages two and three agree.
// ----------------------------------------------------------------
module thc_input_sync #(
   parameter int N = 8,
   parameter logic [N-1:0] INIT = '0
) (
   input wire logic core_clk,
   input wire logic rst,
   thc_sync_if.sync port
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         logic q;
         always_ff @(posedge core_clk) begin
            if (rst) begin
               s1 <= INIT[i];
               s2 <= INIT[i];
               s3 <= INIT[i];
            end else begin
               s1 <= port.raw[i];
               s2 <= s1;
               s3 <= s2;
            end
         end
         always_ff @(posedge core_clk) begin
            if (rst) begin
               q <= INIT[i];
            end else if (s2 == s3) begin
               q <= s3;
            end
         end
         assign port.clean[i] = q;
      end
   endgenerate
endmodule
`default_nettype wire

// ---- thc_two_hand.sv ----
`timescale 1ns/1ps
`default_nettype none
module thc_two_hand #(
   parameter int unsigned SIMULT_CYC = thc_pkg::SIMULT_CYC,
   parameter int unsigned RECOVERY_CYC = thc_pkg::RECOVERY_CYC,
   parameter int unsigned EARTH_OFF_CYC = thc_pkg::EARTH_OFF_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic button_one_no,
   input wire logic button_one_nc,
   input wire logic button_two_no,
   input wire logic button_two_nc,
   input wire logic supply_present,
   input wire logic feedback_loop_input,
   input wire logic earth_fault,
   input wire logic contact_one_closed,
   input wire logic contact_two_closed,
   output logic safety_channel_one,
   output logic safety_channel_two,
   output logic channel_one_indicator,
   output logic channel_two_indicator,
   output logic supply_indicator
);
   localparam int TW = $clog2(SIMULT_CYC + 1);
   localparam int RW = $clog2(RECOVERY_CYC + 1);
   localparam int EW = $clog2(EARTH_OFF_CYC + 1);
   localparam logic [TW-1:0] SIMULT_MAX = TW'(SIMULT_CYC);
   localparam logic [RW-1:0] RECOV_MAX = RW'(RECOVERY_CYC);
   localparam logic [EW-1:0] EARTH_MAX = EW'(EARTH_OFF_CYC);

   // ----------------------------------------------------------------
   // Input conditioning.
   // ----------------------------------------------------------------
   thc_sync_if #(.N(9)) sync_bus ();
   assign sync_bus.raw = {button_one_no, button_one_nc, button_two_no, button_two_nc, supply_present,
                          feedback_loop_input, earth_fault, contact_one_closed, contact_two_closed};
   thc_input_sync #(.N(9), .INIT(9'h0A0)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .port(sync_bus.sync)
   );
   logic b1_no;
   logic b1_nc;
   logic b2_no;
   logic b2_nc;
   logic sup;
   logic fb;
   logic earth;
   logic k1;
   logic k2;
   assign {b1_no, b1_nc, b2_no, b2_nc, sup, fb, earth, k1, k2} = sync_bus.clean;

   // Each button is a changeover pair; both contacts in the same state is a short.
   logic b1_pressed;
   logic b2_pressed;
   logic b1_released;
   logic b2_released;
   logic input_fault;
   assign b1_pressed = b1_no && !b1_nc;
   assign b2_pressed = b2_no && !b2_nc;
   assign b1_released = !b1_no && b1_nc;
   assign b2_released = !b2_no && b2_nc;
   assign input_fault = (b1_no == b1_nc) || (b2_no == b2_nc);
   logic both_released;
   logic any_pressed;
   assign both_released = b1_released && b2_released;
   assign any_pressed = b1_pressed || b2_pressed;

   // ----------------------------------------------------------------
   // Recovery timer: supply present and feedback closed for the recovery time.
   // ----------------------------------------------------------------
   logic [RW-1:0] recov_cnt;
   logic recovered;
   always_ff @(posedge core_clk) begin
      if (rst || !sup || !fb) begin
         recov_cnt <= '0;
      end else if (recov_cnt != RECOV_MAX) begin
         recov_cnt <= recov_cnt + RW'(1);
      end
   end
   assign recovered = (recov_cnt == RECOV_MAX);
   logic ready;
   assign ready = sup && fb && recovered;

   // ----------------------------------------------------------------
   // Earth fault latch, cleared by long supply absence.
   // ----------------------------------------------------------------
   logic earth_lock;
   logic [EW-1:0] off_cnt;
   always_ff @(posedge core_clk) begin
      if (rst || sup) begin
         off_cnt <= '0;
      end else if (off_cnt != EARTH_MAX) begin
         off_cnt <= off_cnt + EW'(1);
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         earth_lock <= 1'b0;
      end else if (earth && sup) begin
         earth_lock <= 1'b1;
      end else if (off_cnt == EARTH_MAX && !earth) begin
         earth_lock <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Welded contact check: both contacts must drop while outputs are open.
   // ----------------------------------------------------------------
   logic welded;
   assign welded = (k1 && !safety_channel_one) || (k2 && !safety_channel_two);

   // ----------------------------------------------------------------
   // Sequence control.
   // ----------------------------------------------------------------
   thc_pkg::thc_state_e state;
   thc_pkg::thc_state_e next_state;
   logic [TW-1:0] win_cnt;
   logic blocked;
   assign blocked = !ready || earth_lock || input_fault || welded;

   always_comb begin
      next_state = state;
      case (state)
         thc_pkg::THC_WAIT_RELEASE: begin
            if (both_released && !input_fault) begin
               next_state = thc_pkg::THC_IDLE;
            end
         end
         thc_pkg::THC_IDLE: begin
            if (any_pressed) begin
               if (blocked) begin
                  next_state = thc_pkg::THC_LOCKED;
               end else if (b1_pressed && b2_pressed) begin
                  next_state = thc_pkg::THC_ACTIVE;
               end else begin
                  next_state = thc_pkg::THC_TIMING;
               end
            end
         end
         thc_pkg::THC_TIMING: begin
            if (blocked) begin
               next_state = thc_pkg::THC_LOCKED;
            end else if (both_released) begin
               next_state = thc_pkg::THC_IDLE;
            end else if (b1_pressed && b2_pressed) begin
               next_state = thc_pkg::THC_ACTIVE;
            end else if (win_cnt == SIMULT_MAX) begin
               next_state = thc_pkg::THC_LOCKED;
            end
         end
         thc_pkg::THC_ACTIVE: begin
            if (!b1_pressed || !b2_pressed || !sup || earth || input_fault) begin
               next_state = thc_pkg::THC_WAIT_RELEASE;
            end
         end
         thc_pkg::THC_LOCKED: begin
            if (both_released) begin
               next_state = thc_pkg::THC_IDLE;
            end
         end
         default: begin
            next_state = thc_pkg::THC_WAIT_RELEASE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= thc_pkg::THC_WAIT_RELEASE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || next_state != thc_pkg::THC_TIMING) begin
         win_cnt <= '0;
      end else begin
         win_cnt <= win_cnt + TW'(1);
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         safety_channel_one <= 1'b0;
         safety_channel_two <= 1'b0;
      end else begin
         safety_channel_one <= (next_state == thc_pkg::THC_ACTIVE);
         safety_channel_two <= (next_state == thc_pkg::THC_ACTIVE);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         channel_one_indicator <= 1'b0;
         channel_two_indicator <= 1'b0;
         supply_indicator <= 1'b0;
      end else begin
         channel_one_indicator <= k1;
         channel_two_indicator <= k2;
         supply_indicator <= sup;
      end
   end
endmodule
`default_nettype wire

// ---- thc_two_hand_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin-level checks of the two-hand block.
// ----
module thc_two_hand_props #(parameter int unsigned SIMULT_CYC = 20) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic button_one_no,
   input wire logic button_one_nc,
   input wire logic button_two_no,
   input wire logic button_two_nc,
   input wire logic supply_present,
   input wire logic feedback_loop_input,
   input wire logic earth_fault,
   input wire logic contact_one_closed,
   input wire logic contact_two_closed,
   input wire logic safety_channel_one,
   input wire logic safety_channel_two,
   input wire logic channel_one_indicator,
   input wire logic channel_two_indicator,
   input wire logic supply_indicator
);
   int unsigned any_cnt;
   int unsigned both_cnt;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge core_clk) begin
      if (rst || !(button_one_no || button_two_no)) any_cnt <= 0;
      else any_cnt <= any_cnt + 1;
   end
   always_ff @(posedge core_clk) begin
      if (rst || !(button_one_no && button_two_no)) both_cnt <= 0;
      else both_cnt <= both_cnt + 1;
   end
   a_channels_paired: assert property (safety_channel_one == safety_channel_two)
      else $error("channels differ");
   a_window_bound: assert property ($rose(safety_channel_one) |-> any_cnt <= SIMULT_CYC + 8)
      else $error("late second press closed outputs");
   a_fresh_pair: assert property ($rose(safety_channel_one) |-> both_cnt < 12)
      else $error("held buttons re-armed");
   a_ready_first: assert property ($rose(safety_channel_one) |-> $past(supply_present, 5)
      && $past(feedback_loop_input, 5)) else $error("closed while not ready");
   a_release_opens: assert property (safety_channel_one && !(button_one_no && button_two_no)
      |-> ##[0:8] !safety_channel_one) else $error("release left outputs closed");
   a_earth_opens: assert property (safety_channel_one && earth_fault |-> ##[0:8] !safety_channel_one)
      else $error("earth fault left outputs closed");
   a_no_weld: assert property ($rose(safety_channel_one) |-> !$past(contact_one_closed, 6)
      && !$past(contact_two_closed, 6)) else $error("closed over a welded contact");
   a_no_short: assert property ($rose(safety_channel_one) |-> !button_one_nc && !button_two_nc)
      else $error("closed with shorted input");
   a_ind_follow: assert property (($stable(contact_one_closed) && $stable(contact_two_closed))[*8]
      |-> channel_one_indicator == contact_one_closed && channel_two_indicator == contact_two_closed)
      else $error("indicator wrong");
   a_supply_led: assert property ($stable(supply_present)[*8] |-> supply_indicator == supply_present)
      else $error("supply indicator wrong");
   c_activate: cover property ($rose(safety_channel_one));
   c_earth: cover property (safety_channel_one && earth_fault);
   c_release: cover property ($fell(safety_channel_one));
endmodule
bind thc_two_hand thc_two_hand_props #(.SIMULT_CYC(SIMULT_CYC)) i_thc_two_hand_props (.*);
`default_nettype wire

// ---- thc_operator_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Two changeover pushbuttons and the feedback loop.
// ----
module thc_operator_model (
   input wire logic press_one,
   input wire logic press_two,
   input wire logic short_one,
   input wire logic loop_closed,
   output wire logic button_one_no,
   output wire logic button_one_nc,
   output wire logic button_two_no,
   output wire logic button_two_nc,
   output wire logic feedback_loop_input
);
   // A short ties both contacts of button one high.
   assign button_one_no = press_one | short_one;
   assign button_one_nc = ~press_one | short_one;
   assign button_two_no = press_two;
   assign button_two_nc = ~press_two;
   assign feedback_loop_input = loop_closed;
endmodule
`default_nettype wire

// ---- thc_two_hand_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
$display("wrong value at %0t: got %b want %b", $time, a, b); end end
module thc_two_hand_tb;
   localparam int unsigned SIM = 20;
   logic core_clk = 1'h0, rst = 1'h1, press_one = 1'h0, press_two = 1'h0, short_one = 1'h0;
   logic loop_closed = 1'h1, supply_present = 1'h1, earth_fault = 1'h0, weld = 1'h0;
   logic contact_one_closed = 1'h0, contact_two_closed = 1'h0;
   logic button_one_no, button_one_nc, button_two_no, button_two_nc, feedback_loop_input;
   logic safety_channel_one, safety_channel_two, channel_one_indicator, channel_two_indicator;
   logic supply_indicator;
   int checks = 0, miscompares = 0, cycles = 0;
   thc_two_hand #(.SIMULT_CYC(SIM), .RECOVERY_CYC(10), .EARTH_OFF_CYC(30)) i_thc_two_hand (.*);
   thc_operator_model i_thc_operator_model (.*);
   always #50 core_clk = ~core_clk;
   // Contacts follow their drive; a weld holds contact one closed.
   always @(posedge core_clk) begin
      #1;
      contact_one_closed = safety_channel_one | weld;
      contact_two_closed = safety_channel_two;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (miscompares == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic arm(input int gap);
      press_one = 1'h1;
      cyc(gap);
      press_two = 1'h1;
      cyc(10);
   endtask
   task automatic drop();
      press_one = 1'h0;
      press_two = 1'h0;
      cyc(12);
   endtask
   task automatic s_normal();
      arm(SIM - 2);
      `CHK(safety_channel_one, 1'h1)
      `CHK(safety_channel_two, 1'h1)
      cyc(10);
      `CHK(channel_two_indicator, 1'h1)
      press_one = 1'h0;
      cyc(8);
      `CHK(safety_channel_two, 1'h0)
      cyc(8);
      `CHK(channel_one_indicator, 1'h0)
      drop();
      arm(SIM + 10);
      `CHK(safety_channel_one, 1'h0)
      drop();
      press_one = 1'h1;
      cyc(SIM - 5);
      press_one = 1'h0;
      cyc(12);
      arm(SIM - 2);
      `CHK(safety_channel_one, 1'h1)
      drop();
   endtask
   task automatic s_held();
      arm(5);
      press_two = 1'h0;
      cyc(10);
      `CHK(safety_channel_one, 1'h0)
      press_two = 1'h1;
      cyc(10);
      `CHK(safety_channel_one, 1'h0)
      drop();
      loop_closed = 1'h0;
      arm(5);
      `CHK(safety_channel_one, 1'h0)
      drop();
      loop_closed = 1'h1;
      arm(2);
      `CHK(safety_channel_one, 1'h0)
      drop();
      arm(5);
      `CHK(safety_channel_one, 1'h1)
      drop();
   endtask
   task automatic s_faults();
      short_one = 1'h1;
      arm(5);
      `CHK(safety_channel_one, 1'h0)
      short_one = 1'h0;
      drop();
      weld = 1'h1;
      arm(5);
      `CHK(safety_channel_two, 1'h0)
      weld = 1'h0;
      drop();
   endtask
   task automatic s_earth();
      arm(5);
      earth_fault = 1'h1;
      cyc(8);
      `CHK(safety_channel_one, 1'h0)
      drop();
      earth_fault = 1'h0;
      arm(5);
      `CHK(safety_channel_one, 1'h0)
      drop();
      supply_present = 1'h0;
      cyc(10);
      `CHK(supply_indicator, 1'h0)
      cyc(30);
      supply_present = 1'h1;
      cyc(20);
      `CHK(supply_indicator, 1'h1)
      arm(5);
      `CHK(safety_channel_one, 1'h1)
      drop();
   endtask
   initial begin
      cyc(12);
      rst = 1'h0;
      cyc(30);
      s_normal();
      s_held();
      s_faults();
      s_earth();
      finish_test();
   end
endmodule
`default_nettype wire
